// ---- hw/dfas_pkg.sv ----
/*
 * constants for the drive fault and alarm status bank: parameter codes,
 * implemented-bit masks, named bit positions and reset values.
 * assumes the serial link handler presents parameter codes as addresses.
 */
package dfas_pkg;

    localparam int DFAS_AW = 9;
    localparam int DFAS_DW = 16;

    // parameter codes of the status group
    localparam logic [8:0] DFAS_CMD_MIRROR_ADDR = 9'h12d;
    localparam logic [8:0] DFAS_STS_MIRROR_ADDR = 9'h12e;
    localparam logic [8:0] DFAS_FAULT_A_ADDR = 9'h131;
    localparam logic [8:0] DFAS_FAULT_B_ADDR = 9'h132;
    localparam logic [8:0] DFAS_WARN_A_ADDR = 9'h134;
    localparam logic [8:0] DFAS_WARN_B_ADDR = 9'h135;

    // implemented bits; reserved bits read as zero
    localparam logic [15:0] DFAS_FAULT_A_MASK = 16'hffff;
    localparam logic [15:0] DFAS_FAULT_B_MASK = 16'h0105;
    localparam logic [15:0] DFAS_WARN_A_MASK = 16'h3fff;
    localparam logic [15:0] DFAS_WARN_B_MASK = 16'h001f;

    // named positions of note
    localparam int DFAS_FA_OVERCURRENT = 0;
    localparam int DFAS_FA_GROUND_FAULT = 15;
    localparam int DFAS_FB_UNDERLOAD = 0;
    localparam int DFAS_FB_OPTICAL_LINK = 2;
    localparam int DFAS_FB_HW_ERROR = 8;
    localparam int DFAS_WA_COMM_LOSS = 4;
    localparam int DFAS_WA_OPTICAL_LINK = 13;

    // reset values and the only accepted write value
    localparam logic [15:0] DFAS_WORD_RESET = 16'h0000;
    localparam logic [15:0] DFAS_CLEAR_VALUE = 16'h0000;

endpackage : dfas_pkg

// ---- hw/dfas_warn_latch.sv ----
/*
 * one latched warning word: each bit sets while its condition is active
 * and holds until the whole word is cleared.
 * assumes condition inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module dfas_warn_latch #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] MASK = '1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // conditions and whole-word clear
    input wire logic [WIDTH-1:0] cond,
    input wire logic clear,
    // latched word
    output logic [WIDTH-1:0] flags
);
    import dfas_pkg::*;

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    ////////////////////////////////////////////////////////////////////
    // set beats clear so an alarm in the clear cycle survives
    always_comb begin
        if (clear) begin
            flags_next = cond & MASK;
        end else begin
            flags_next = (flags_reg | cond) & MASK;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_reg <= WIDTH'(DFAS_WORD_RESET);
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule : dfas_warn_latch

// ---- hw/dfas_status_bank.sv ----
/*
 * drive fault and alarm status bank: command/status mirrors, two live
 * fault words and two latched warning words, read over the serial link
 * parameter port; the keypad port is refused.
 * the two warning words live in a small latch module of their own;
 * everything else is in this file.
 * assumes all condition and word inputs are on core_clk, and that the
 * link handler issues one-cycle requests.
 * assumes the link handler maps parameter codes onto comm_addr and
 * tolerates an answer one cycle after each request.
 * assumes the keypad handler treats a denial as "no such parameter".
 */
`timescale 1ns/1ps
module dfas_status_bank (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // live drive words and conditions
    input wire logic [dfas_pkg::DFAS_DW-1:0] cmd_word,
    input wire logic [dfas_pkg::DFAS_DW-1:0] sts_word,
    input wire logic [dfas_pkg::DFAS_DW-1:0] fault_cond_a,
    input wire logic [dfas_pkg::DFAS_DW-1:0] fault_cond_b,
    input wire logic [dfas_pkg::DFAS_DW-1:0] warn_cond_a,
    input wire logic [dfas_pkg::DFAS_DW-1:0] warn_cond_b,
    // serial link parameter port
    input wire logic comm_req,
    input wire logic comm_we,
    input wire logic [dfas_pkg::DFAS_AW-1:0] comm_addr,
    input wire logic [dfas_pkg::DFAS_DW-1:0] comm_wdata,
    output logic comm_ack,
    output logic comm_unmapped,
    output logic [dfas_pkg::DFAS_DW-1:0] comm_rdata,
    // keypad parameter port
    input wire logic pad_req,
    input wire logic [dfas_pkg::DFAS_AW-1:0] pad_addr,
    output logic pad_ack,
    output logic pad_denied,
    output logic [dfas_pkg::DFAS_DW-1:0] pad_rdata
);
    import dfas_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // timing seen from the serial link handler:
    //   edge n   request taken (comm_req high, we/addr/wdata valid)
    //   edge n+1 comm_ack high for one cycle; comm_rdata and
    //            comm_unmapped valid and held until the next request
    // live words lag their sources by one edge, so a read returns what
    // the drive showed one edge before the request was taken.
    // a clear in the same cycle as a new alarm keeps the alarm: losing
    // an alarm to a badly timed clear is the worse failure.
    // the keypad port answers every request with a denial and zeros.

    // mirrored command and status words
    logic [DFAS_DW-1:0] cmd_mirror_reg;
    logic [DFAS_DW-1:0] cmd_mirror_next;
    logic [DFAS_DW-1:0] sts_mirror_reg;
    logic [DFAS_DW-1:0] sts_mirror_next;
    // live fault words
    logic [DFAS_DW-1:0] fault_a_reg;
    logic [DFAS_DW-1:0] fault_a_next;
    logic [DFAS_DW-1:0] fault_b_reg;
    logic [DFAS_DW-1:0] fault_b_next;
    // latched warning words and their whole-word clears
    logic [DFAS_DW-1:0] warn_a;
    logic [DFAS_DW-1:0] warn_b;
    logic clear_a;
    logic clear_b;
    // read decode
    logic in_group;
    logic [DFAS_DW-1:0] read_val;
    // serial answer registers
    logic comm_ack_reg;
    logic comm_ack_next;
    logic comm_unm_reg;
    logic comm_unm_next;
    logic [DFAS_DW-1:0] comm_rdata_reg;
    logic [DFAS_DW-1:0] comm_rdata_next;
    // keypad answer registers
    logic pad_ack_reg;
    logic pad_ack_next;
    logic pad_den_reg;
    logic pad_den_next;
    logic [DFAS_DW-1:0] pad_rdata_reg;
    logic [DFAS_DW-1:0] pad_rdata_next;

    ////////////////////////////////////////////////////////////////////
    // live words: mirrors follow their sources, faults follow theirs masked to the implemented bits
    always_comb begin
        cmd_mirror_next = cmd_word;
        sts_mirror_next = sts_word;
        fault_a_next = fault_cond_a & DFAS_FAULT_A_MASK;
        fault_b_next = fault_cond_b & DFAS_FAULT_B_MASK;
    end

    // live word registers; zero in reset, the drive's value follows on
    // the first edge after release
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_mirror_reg <= DFAS_WORD_RESET;
            sts_mirror_reg <= DFAS_WORD_RESET;
            fault_a_reg <= DFAS_WORD_RESET;
            fault_b_reg <= DFAS_WORD_RESET;
        end else begin
            cmd_mirror_reg <= cmd_mirror_next;
            sts_mirror_reg <= sts_mirror_next;
            fault_a_reg <= fault_a_next;
            fault_b_reg <= fault_b_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // only an exact zero write to a warning word clears it; all other
    // writes fall through silently, so a stray write cannot mask alarms
    always_comb begin
        clear_a = comm_req && comm_we && (comm_addr == DFAS_WARN_A_ADDR)
            && (comm_wdata == DFAS_CLEAR_VALUE);
        clear_b = comm_req && comm_we && (comm_addr == DFAS_WARN_B_ADDR)
            && (comm_wdata == DFAS_CLEAR_VALUE);
    end

    // first word: bits 14 and 15 are reserved and masked off
    dfas_warn_latch #(
        .WIDTH(DFAS_DW),
        .MASK(DFAS_WARN_A_MASK)
    ) u_warn_a (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cond(warn_cond_a),
        .clear(clear_a),
        .flags(warn_a)
    );

    // second word: only the five low alarm bits exist
    dfas_warn_latch #(
        .WIDTH(DFAS_DW),
        .MASK(DFAS_WARN_B_MASK)
    ) u_warn_b (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cond(warn_cond_b),
        .clear(clear_b),
        .flags(warn_b)
    );

    ////////////////////////////////////////////////////////////////////
    // read decode over the group codes
    always_comb begin
        in_group = 1'b1;
        read_val = DFAS_WORD_RESET;
        unique case (comm_addr)
            DFAS_CMD_MIRROR_ADDR: read_val = cmd_mirror_reg;
            DFAS_STS_MIRROR_ADDR: read_val = sts_mirror_reg;
            DFAS_FAULT_A_ADDR: read_val = fault_a_reg;
            DFAS_FAULT_B_ADDR: read_val = fault_b_reg;
            DFAS_WARN_A_ADDR: read_val = warn_a;
            DFAS_WARN_B_ADDR: read_val = warn_b;
            default: in_group = 1'b0;
        endcase
    end

    // serial answer one cycle after the request; read data hold until
    // the next request so the link handler may sample late
    always_comb begin
        comm_ack_next = comm_req;
        comm_unm_next = comm_unm_reg;
        comm_rdata_next = comm_rdata_reg;
        if (comm_req) begin
            comm_unm_next = !in_group;
            // writes answer with zero data; comm_unmapped still follows the address decode
            comm_rdata_next = comm_we ? DFAS_WORD_RESET : read_val;
        end
    end

    // keypad has no read path: every request is denied, data stay zero
    always_comb begin
        pad_ack_next = pad_req;
        pad_den_next = pad_req;
        pad_rdata_next = DFAS_WORD_RESET;
    end

    // answer registers; every port output comes from one of these
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            comm_ack_reg <= 1'b0;
            comm_unm_reg <= 1'b0;
            comm_rdata_reg <= DFAS_WORD_RESET;
            pad_ack_reg <= 1'b0;
            pad_den_reg <= 1'b0;
            pad_rdata_reg <= DFAS_WORD_RESET;
        end else begin
            comm_ack_reg <= comm_ack_next;
            comm_unm_reg <= comm_unm_next;
            comm_rdata_reg <= comm_rdata_next;
            pad_ack_reg <= pad_ack_next;
            pad_den_reg <= pad_den_next;
            pad_rdata_reg <= pad_rdata_next;
        end
    end

    // pad_addr is accepted but never decoded: nothing is reachable
    assign comm_ack = comm_ack_reg;
    assign comm_unmapped = comm_unm_reg;
    assign comm_rdata = comm_rdata_reg;
    assign pad_ack = pad_ack_reg;
    assign pad_denied = pad_den_reg;
    assign pad_rdata = pad_rdata_reg;

endmodule : dfas_status_bank

// ---- tb/dfas_status_bank_properties.sv ----
/* checker on the status bank ports, bound after the module.
 * assumes one clock and rst_b async low. */
`timescale 1ns/1ps
module dfas_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // words
    input wire logic [15:0] cmd_word,
    input wire logic [15:0] fault_cond_b,
    input wire logic [15:0] warn_cond_a,
    // serial and keypad ports
    input wire logic comm_req,
    input wire logic comm_we,
    input wire logic [8:0] comm_addr,
    input wire logic comm_ack,
    input wire logic comm_unmapped,
    input wire logic [15:0] comm_rdata,
    input wire logic pad_req,
    input wire logic pad_denied
);
    logic up_reg;
    // skips the first edge, where words are still zero
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            up_reg <= 1'b0;
        else
            up_reg <= 1'b1;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_rd(a);
        up_reg && comm_req && !comm_we && comm_addr == a;
    endsequence
    sequence s_seen;
        up_reg && warn_cond_a[4] ##1 !(comm_req && comm_we);
    endsequence
    property p_ack; comm_req |=> comm_ack; endproperty
    property p_idle; !comm_req |=> !comm_ack; endproperty
    property p_cmd; s_rd(9'h12d) |=> comm_rdata == $past(cmd_word, 2);
    endproperty
    property p_fb; s_rd(9'h132) |=>
        comm_rdata == ($past(fault_cond_b, 2) & 16'h0105); endproperty
    property p_res; s_rd(9'h134) |=> comm_rdata[15:14] == 2'h0; endproperty
    property p_latch; s_seen ##1 s_rd(9'h134) |=> comm_rdata[4];
    endproperty
    property p_wr; up_reg && comm_req && comm_we |=> comm_rdata == 16'h0;
    endproperty
    property p_unm; comm_req && comm_addr == 9'h133 |=>
        comm_unmapped && comm_rdata == 16'h0; endproperty
    property p_pad; pad_req |=> pad_denied; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    a_idle: assert property (p_idle) else $error("stray ack");
    a_cmd: assert property (p_cmd) else $error("bad mirror");
    a_fb: assert property (p_fb) else $error("bad fault b");
    a_res: assert property (p_res) else $error("reserved set");
    a_latch: assert property (p_latch) else $error("not latched");
    a_wr: assert property (p_wr) else $error("write data");
    a_unm: assert property (p_unm) else $error("unmapped");
    a_pad: assert property (p_pad) else $error("keypad read");
endmodule : dfas_props
bind dfas_status_bank dfas_props u_props (.*);

// ---- tb/dfas_host.sv ----
/* host side of the serial parameter port.
 * assumes the bench calls xfer one transfer at a time. */
`timescale 1ns/1ps
module dfas_host (
    // clock
    input wire logic core_clk,
    // request
    output logic comm_req,
    output logic comm_we,
    output logic [8:0] comm_addr,
    output logic [15:0] comm_wdata,
    // answer
    input wire logic comm_ack,
    input wire logic comm_unmapped,
    input wire logic [15:0] comm_rdata
);
    // idle before the first request
    initial begin
        comm_req = 1'b0;
        comm_we = 1'b0;
        comm_addr = 9'h0;
        comm_wdata = 16'h0;
    end
    // one-cycle request; on release addr and wdata are scrambled, not left stale, and we stays as driven
    task automatic xfer(input logic w, input logic [8:0] a,
            input logic [15:0] d, output logic [15:0] q,
            output logic u, output logic k);
        @(posedge core_clk);
        comm_req <= 1'b1;
        comm_we <= w;
        comm_addr <= a;
        comm_wdata <= d;
        // taken at this edge; the request is a pulse, so drop it here
        @(posedge core_clk);
        comm_req <= 1'b0;
        comm_addr <= ~a;
        comm_wdata <= ~d;
        // the ack stands one cycle only: take it at the next edge
        @(posedge core_clk);
        q = comm_rdata;
        u = comm_unmapped;
        k = comm_ack;
    endtask : xfer
endmodule : dfas_host

// ---- tb/dfas_status_bank_tb.sv ----
/* self-checking bench for the status bank.
 * assumes the host model and a fixed seed of 89. */
`timescale 1ns/1ps
module dfas_status_bank_tb;
    import dfas_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] cmd_word, sts_word, fault_cond_a, fault_cond_b;
    logic [15:0] warn_cond_a, warn_cond_b, comm_wdata, comm_rdata;
    logic [15:0] pad_rdata, q, wdat, ea, eb;
    logic comm_req, comm_we, comm_ack, comm_unmapped, u, k;
    logic pad_req, pad_ack, pad_denied;
    logic [8:0] comm_addr, pad_addr, a;
    logic [8:0] amap [8];
    logic [16:0] e;
    logic [31:0] rs = 32'd89;
    int n_fail = 0;
    int check_count = 0;
    dfas_status_bank uut (.*);
    dfas_host host (.*);
    initial forever #50 core_clk = ~core_clk;
    function automatic logic [15:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[15:0];
    endfunction : rnd
    // {unmapped, data} a read should return
    function automatic logic [16:0] exp_rd(input logic [8:0] ad);
        case (ad)
            DFAS_CMD_MIRROR_ADDR: return {1'b0, cmd_word};
            DFAS_STS_MIRROR_ADDR: return {1'b0, sts_word};
            DFAS_FAULT_A_ADDR: return {1'b0, fault_cond_a};
            DFAS_FAULT_B_ADDR: return {1'b0, fault_cond_b & 16'h0105};
            DFAS_WARN_A_ADDR: return {1'b0, ea};
            DFAS_WARN_B_ADDR: return {1'b0, eb};
            default: return 17'h10000;
        endcase
    endfunction : exp_rd
    task automatic chk(input logic [17:0] seen, input logic [17:0] want);
        check_count++;
        if (seen !== want) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // generous: a full run takes about 1200 cycles
    initial begin
        #1000000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {cmd_word, sts_word, fault_cond_a, fault_cond_b} = '0;
        {warn_cond_a, warn_cond_b, ea, eb} = '0;
        {pad_req, pad_addr} = '0;
        amap = '{9'h12d, 9'h12e, 9'h131, 9'h132, 9'h134, 9'h135, 9'h133, 0};
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            // first pass drives every fault and warning condition to all ones, reserved bits too
            @(posedge core_clk);
            cmd_word <= rnd();
            sts_word <= rnd();
            fault_cond_a <= rnd() | {16{i == 0}};
            fault_cond_b <= rnd() | {16{i == 0}};
            warn_cond_a <= (rnd() & rnd()) | {16{i == 0}};
            warn_cond_b <= (rnd() & rnd()) | {16{i == 0}};
            pad_req <= 1'b1;
            pad_addr <= 9'(rnd());
            @(posedge core_clk);
            pad_req <= 1'b0;
            // denial pulse stands one cycle after the taking edge
            @(posedge core_clk);
            chk({pad_ack, pad_denied, pad_rdata}, {2'b11, 16'h0});
            ea = ea | (warn_cond_a & 16'h3fff);
            eb = eb | (warn_cond_b & 16'h001f);
            amap[7] = 9'(rnd());
            foreach (amap[j]) begin
                host.xfer(1'b0, amap[j], 16'h0, q, u, k);
                chk({k, u, q}, {1'b1, exp_rd(amap[j])});
            end
            a = amap[rnd() % 8];
            wdat = rnd();
            if (wdat[0])
                wdat = 16'h0;
            e = exp_rd(a);
            host.xfer(1'b1, a, wdat, q, u, k);
            chk({k, u, q}, {1'b1, e[16], 16'h0});
            if (wdat == 16'h0 && a == DFAS_WARN_A_ADDR)
                ea = warn_cond_a & 16'h3fff;
            if (wdat == 16'h0 && a == DFAS_WARN_B_ADDR)
                eb = warn_cond_b & 16'h001f;
        end
        // mid-run reset wipes the latched alarms
        @(posedge core_clk);
        rst_b <= 1'b0;
        warn_cond_a <= 16'h0;
        warn_cond_b <= 16'h0;
        @(posedge core_clk);
        rst_b <= 1'b1;
        ea = 16'h0;
        eb = 16'h0;
        host.xfer(1'b0, DFAS_WARN_A_ADDR, 16'h0, q, u, k);
        chk({k, u, q}, {1'b1, exp_rd(DFAS_WARN_A_ADDR)});
        tally_and_finish();
    end
endmodule : dfas_status_bank_tb
